/* inc/hpu_regs.svh */
/*
 * register offsets, field positions, reset values and pin codes of the
 * host pixel unpacker. assumes a 32-bit apb with byte addresses.
 */
`ifndef HPU_REGS_SVH
`define HPU_REGS_SVH

// ==========================================================
// register map
`define HPU_OFS_CTRL      12'h000
`define HPU_OFS_STATUS    12'h004

// ==========================================================
// control fields
`define HPU_CTRL_FMT_LSB  0
`define HPU_CTRL_ZINV_BIT 4
`define HPU_CTRL_D18_BIT  8
`define HPU_CTRL_RESET    32'h0000_0000

// ==========================================================
// pin and format codes, pixels per row
`define HPU_IM_BUS18      3'h0
`define HPU_IM_BUS9       3'h1
`define HPU_IM_BUS16      3'h2
`define HPU_FMT_RGB16     3'h5
`define HPU_FMT_RGB18     3'h6
`define HPU_ROW_PIXELS    9'h140

`endif

/* inc/hpu_pkg.sv */
/*
 * types of the host pixel unpacker.
 * assumes the constants header is included where offsets are used.
 */
package hpu_pkg;

   // ==========================================================
   // operating modes
   typedef enum logic [2:0] {
      MODE_IDLE,
      MODE_MCU9,
      MODE_MCU16,
      MODE_MCU18,
      MODE_RGB16,
      MODE_RGB18
   } hpu_mode_t;

   // ==========================================================
   // pins sampled from outside the clock domain
   typedef struct packed {
      logic        pixclk;
      logic        vsync_n;
      logic        hsync_n;
      logic        de;
      logic        wr_n;
      logic        dc;
      logic [2:0]  im;
      logic [17:0] data;
   } hpu_pins_t;

   // ==========================================================
   // whole module state
   typedef struct packed {
      hpu_pins_t   sync1;
      hpu_pins_t   sync2;
      hpu_pins_t   prev;
      logic [2:0]  fmt;
      logic        zinv;
      logic        d18;
      hpu_mode_t   mode;
      logic        half;
      logic [11:0] part;
      logic [8:0]  col;
      logic        even;
      logic        pol;
      logic        vs_low;
      logic        hs_low;
      logic [15:0] pixcnt;
      logic        wr_en;
      logic [17:0] pix;
      logic        frame;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } hpu_state_t;

endpackage

/* rtl/hpu_unpacker.sv */
/*
 * host pixel unpacker: parallel mcu bus (9/16/18 bit) and 16/18-bit
 * video port to frame-memory write words, with z-inversion reorder.
 * assumes pclk at 10 MHz, all pins asynchronous to pclk, apb master.
 */
// Operation
// - 9-bit bus, 18 bpp: two transfers per pixel, D8 is msb.
// - select pins 010 pick the 16-bit bus, 16 or 18 bpp.
// - 16-bit bus, 16 bpp: one transfer, 5-6-5 on D15..D0.
// - 16-bit bus, 18 bpp: two transfers joined into one pixel.
// - select pins 000 pick the 18-bit bus, 6-6-6 only.
// - 18-bit bus: one transfer per pixel, D17 is msb.
// - pixel format field 101 selects 16-bit video port.
// - 16-bit video uses D15..D0 with syncs and pixel clock.
// - pixel format field 110 selects 18-bit video port.
// - 18-bit video writes only while data enable is high.
// - configuration goes over the register bus, not the video port.
// - z-inversion drives one extra data line per row.
// - z-inversion odd lines: red, green, blue in normal order.
// - z-inversion even lines: green, blue, red, one sub-pixel shift.
// - z-inversion uses column polarity yet looks like dot inversion.
// - video pins sampled on pixel clock rise; syncs low, enable high.
`timescale 1ns/1ps
`default_nettype none
`include "hpu_regs.svh"

module hpu_unpacker
   import hpu_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        pclken,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [2:0]  interface_select_pins,
   input  wire logic        mcu_wr_n,
   input  wire logic        mcu_dc,
   input  wire logic        pixel_clock_pin,
   input  wire logic        vsync_n,
   input  wire logic        hsync_n,
   input  wire logic        data_enable,
   input  wire logic [17:0] video_data_lines,
   output logic             frame_memory_wr_en,
   output logic      [17:0] frame_memory_wr_data,
   output logic             frame_memory_frame_start,
   output logic             gate_line_even,
   output logic             zinv_extra_line_en,
   output logic             source_polarity
);

   // ==========================================================
   // state
   hpu_state_t  st_ff;
   hpu_state_t  nxt_st;
   hpu_pins_t   pins_in;
   hpu_pins_t   s2;
   hpu_pins_t   pv;
   hpu_mode_t   mode_sel;
   logic        wr_edge;
   logic        pix_rise;
   logic        vs_fall;
   logic        hs_fall;
   logic        mcu_ev;
   logic        vid_ev;
   logic        done;
   logic [17:0] pix_raw;
   logic [17:0] pix_out;
   logic        apb_setup;
   logic        apb_commit;
   logic        hit_ctrl;
   logic        hit_stat;

   assign pins_in = '{pixclk:  pixel_clock_pin,
                      vsync_n: vsync_n,
                      hsync_n: hsync_n,
                      de:      data_enable,
                      wr_n:    mcu_wr_n,
                      dc:      mcu_dc,
                      im:      interface_select_pins,
                      data:    video_data_lines};

   // only the second stage and its delayed copy are read
   assign s2 = st_ff.sync2;
   assign pv = st_ff.prev;

   // ==========================================================
   // mode decode
   function automatic hpu_mode_t decode(input logic [2:0] fmt,
                                        input logic [2:0] im);
      hpu_mode_t m;
      m = MODE_IDLE;
      if (fmt == `HPU_FMT_RGB16) begin
         m = MODE_RGB16;
      end else if (fmt == `HPU_FMT_RGB18) begin
         m = MODE_RGB18;
      end else if (im == `HPU_IM_BUS18) begin
         m = MODE_MCU18;
      end else if (im == `HPU_IM_BUS9) begin
         m = MODE_MCU9;
      end else if (im == `HPU_IM_BUS16) begin
         m = MODE_MCU16;
      end
      return m;
   endfunction

   // 5-6-5 widened by copying each msb into the new lsb
   function automatic logic [17:0] widen565(input logic [15:0] d);
      return {d[15:11], d[15], d[10:5], d[4:0], d[4]};
   endfunction

   assign mode_sel = decode(st_ff.fmt, s2.im);

   // ==========================================================
   // pin events
   // pixel clock edges only exist while the host keeps the pixel clock running; write strobe edges do not need it
   assign pix_rise = s2.pixclk & ~pv.pixclk;
   assign wr_edge  = s2.wr_n & ~pv.wr_n;
   // syncs are active low; a fall is judged between two pixel clock rises,
   // since the host may move them well before the rise that samples them
   assign vs_fall  = pix_rise & ~s2.vsync_n & ~st_ff.vs_low;
   assign hs_fall  = pix_rise & ~s2.hsync_n & ~st_ff.hs_low;
   assign mcu_ev   = wr_edge & s2.dc &
                     (mode_sel inside {MODE_MCU9, MODE_MCU16, MODE_MCU18});
   assign vid_ev   = pix_rise & s2.de &
                     (mode_sel inside {MODE_RGB16, MODE_RGB18});

   // ==========================================================
   // pixel assembly
   always_comb begin
      pix_raw = '0;
      done    = 1'b0;
      unique case (mode_sel)
         MODE_MCU18: begin
            pix_raw = s2.data;
            done    = mcu_ev;
         end
         MODE_MCU9: begin
            // D17..D9 are don't care on this bus
            pix_raw = {st_ff.part[8:0], s2.data[8:0]};
            done    = mcu_ev & st_ff.half;
         end
         MODE_MCU16: begin
            if (st_ff.d18) begin
               pix_raw = {st_ff.part, s2.data[15:10]};
               done    = mcu_ev & st_ff.half;
            end else begin
               pix_raw = widen565(s2.data[15:0]);
               done    = mcu_ev;
            end
         end
         MODE_RGB16: begin
            // D17/D16 are left open by the host and never read
            pix_raw = widen565(s2.data[15:0]);
            done    = vid_ev;
         end
         MODE_RGB18: begin
            pix_raw = s2.data;
            done    = vid_ev;
         end
         MODE_IDLE: begin
            pix_raw = '0;
            done    = 1'b0;
         end
      endcase
   end

   // with z-inversion on, even gate lines take green, blue, red onto r, g, b sub-pixels
   assign pix_out = (st_ff.zinv && st_ff.even) ?
                    {pix_raw[11:6], pix_raw[5:0], pix_raw[17:12]} :
                    pix_raw;

   // ==========================================================
   // register bus decode
   assign apb_setup  = psel & penable & ~st_ff.pready;
   assign apb_commit = psel & penable & st_ff.pready;
   assign hit_ctrl   = (paddr == `HPU_OFS_CTRL);
   assign hit_stat   = (paddr == `HPU_OFS_STATUS);

   // ==========================================================
   // next state
   always_comb begin
      nxt_st       = st_ff;
      nxt_st.sync1 = pins_in;
      nxt_st.sync2 = st_ff.sync1;
      nxt_st.prev  = st_ff.sync2;
      nxt_st.wr_en = 1'b0;
      nxt_st.frame = 1'b0;
      nxt_st.mode  = mode_sel;

      // a switch of bus or format drops any half-built pixel unless a transfer in that same cycle completes it
      if (mode_sel != st_ff.mode) begin
         nxt_st.half = 1'b0;
         nxt_st.col  = '0;
         nxt_st.even = 1'b0;
      end else if (mcu_ev && !done) begin
         nxt_st.half = 1'b1;
         if (mode_sel == MODE_MCU9) begin
            nxt_st.part = {3'h0, s2.data[8:0]};
         end else begin
            nxt_st.part = {s2.data[15:10], s2.data[7:2]};
         end
      end

      if (done) begin
         nxt_st.half   = 1'b0;
         nxt_st.wr_en  = 1'b1;
         nxt_st.pix    = pix_out;
         nxt_st.pixcnt = st_ff.pixcnt + 16'h0001;
         // the mcu bus has no line sync, so rows are counted in pixels
         if (mcu_ev) begin
            if (st_ff.col == `HPU_ROW_PIXELS - 9'h001) begin
               nxt_st.col  = '0;
               nxt_st.even = ~st_ff.even;
            end else begin
               nxt_st.col = st_ff.col + 9'h001;
            end
         end
      end

      if (pix_rise) begin
         nxt_st.vs_low = ~s2.vsync_n;
         nxt_st.hs_low = ~s2.hsync_n;
      end

      if (mode_sel inside {MODE_RGB16, MODE_RGB18}) begin
         if (vs_fall) begin
            // first line sync of the frame brings the row to odd
            nxt_st.even  = 1'b1;
            nxt_st.frame = 1'b1;
            nxt_st.pol   = ~st_ff.pol;
         end
         if (hs_fall) begin
            nxt_st.even = vs_fall ? 1'b0 : ~st_ff.even;
         end
      end

      // registers are only reached over the bus
      if (apb_setup) begin
         nxt_st.pready  = 1'b1;
         nxt_st.pslverr = ~(hit_ctrl | hit_stat);
         nxt_st.prdata  = '0;
         if (!pwrite && hit_ctrl) begin
            nxt_st.prdata = {23'h0, st_ff.d18, 3'h0, st_ff.zinv,
                             1'b0, st_ff.fmt};
         end else if (!pwrite && hit_stat) begin
            nxt_st.prdata = {st_ff.pixcnt, 8'h00, 2'h0, st_ff.pol,
                             st_ff.even, st_ff.half, st_ff.mode};
         end
      end else if (apb_commit) begin
         nxt_st.pready  = 1'b0;
         nxt_st.pslverr = 1'b0;
         if (pwrite && hit_ctrl) begin
            nxt_st.fmt  = pwdata[`HPU_CTRL_FMT_LSB +: 3];
            nxt_st.zinv = pwdata[`HPU_CTRL_ZINV_BIT];
            nxt_st.d18  = pwdata[`HPU_CTRL_D18_BIT];
         end
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff            <= '0;
         // strobe stages start idle so that release gives no false edge
         st_ff.sync1.wr_n <= 1'b1;
         st_ff.sync2.wr_n <= 1'b1;
         st_ff.prev.wr_n  <= 1'b1;
      end else if (pclken) begin
         st_ff <= nxt_st;
      end
   end

   // ==========================================================
   // outputs
   assign prdata                   = st_ff.prdata;
   assign pready                   = st_ff.pready;
   assign pslverr                  = st_ff.pslverr;
   assign frame_memory_wr_en       = st_ff.wr_en;
   assign frame_memory_wr_data     = st_ff.pix;
   assign frame_memory_frame_start = st_ff.frame;
   assign gate_line_even           = st_ff.even;
   // one sub-pixel longer row while z-inversion is on
   assign zinv_extra_line_en       = st_ff.zinv;
   assign source_polarity          = st_ff.pol;

   // ==========================================================
   // checks
   a_bus18_single: assert property (
      @(posedge pclk) disable iff (!presetn)
      pclken && mode_sel == MODE_MCU18 && mcu_ev && !st_ff.zinv
      |=> frame_memory_wr_en && frame_memory_wr_data == $past(s2.data))
      else $error("18-bit bus pixel not written in one transfer");

   a_bus9_first: assert property (
      @(posedge pclk) disable iff (!presetn)
      pclken && mode_sel == MODE_MCU9 && mode_sel == st_ff.mode
         && mcu_ev && !st_ff.half
      |=> !frame_memory_wr_en && st_ff.half)
      else $error("9-bit bus wrote on first transfer");

   a_bus9_join: assert property (
      @(posedge pclk) disable iff (!presetn)
      pclken && mode_sel == MODE_MCU9 && mcu_ev && st_ff.half && !st_ff.zinv
      |=> frame_memory_wr_en
          && frame_memory_wr_data == {$past(st_ff.part[8:0]), $past(s2.data[8:0])})
      else $error("9-bit bus pixel not joined");

   a_bus16_wide: assert property (
      @(posedge pclk) disable iff (!presetn)
      pclken && mode_sel == MODE_MCU16 && !st_ff.d18 && mcu_ev && !st_ff.zinv
      |=> frame_memory_wr_en
          && frame_memory_wr_data[17:12] == {$past(s2.data[15:11]), $past(s2.data[15])})
      else $error("16-bit bus 5-6-5 pixel wrong");

   a_bus16_pair: assert property (
      @(posedge pclk) disable iff (!presetn)
      pclken && mode_sel == MODE_MCU16 && st_ff.d18 && mcu_ev && st_ff.half
         && !st_ff.zinv
      |=> frame_memory_wr_en && frame_memory_wr_data[5:0] == $past(s2.data[15:10]))
      else $error("16-bit bus 18 bpp second transfer wrong");

   a_video_qual: assert property (
      @(posedge pclk) disable iff (!presetn)
      pclken && mode_sel == MODE_RGB18 && pix_rise && !s2.de && !mcu_ev
      |=> !frame_memory_wr_en)
      else $error("video word written without data enable");

   a_format_sel: assert property (
      @(posedge pclk) disable iff (!presetn)
      pclken && st_ff.fmt == `HPU_FMT_RGB16 |=> st_ff.mode == MODE_RGB16)
      else $error("16-bit video mode not selected");

   a_format_18: assert property (
      @(posedge pclk) disable iff (!presetn)
      pclken && st_ff.fmt == `HPU_FMT_RGB18 |=> st_ff.mode == MODE_RGB18)
      else $error("18-bit video mode not selected");

   a_zinv_even: assert property (
      @(posedge pclk) disable iff (!presetn)
      pclken && done && st_ff.zinv && st_ff.even
      |=> frame_memory_wr_data == {$past(pix_raw[11:0]), $past(pix_raw[17:12])})
      else $error("even line sub-pixels not rotated");

   a_zinv_odd: assert property (
      @(posedge pclk) disable iff (!presetn)
      pclken && done && !st_ff.even |=> frame_memory_wr_data == $past(pix_raw))
      else $error("odd line sub-pixels reordered");

   a_frame_pol: assert property (
      @(posedge pclk) disable iff (!presetn)
      pclken && vs_fall && (mode_sel inside {MODE_RGB16, MODE_RGB18})
      |=> source_polarity != $past(source_polarity) && frame_memory_frame_start)
      else $error("polarity did not flip at frame start");

endmodule // hpu_unpacker
`default_nettype wire

/* bench/hpu_host_model.sv */
/*
 * host side model: mcu write strobes and video port pins of the unpacker.
 * assumes pclk from the bench; every pin moves just after a pclk rise.
 */
`timescale 1ns/1ps
`default_nettype none

module hpu_host_model (
   input  wire logic        pclk,
   output logic      [2:0]  interface_select_pins,
   output logic             mcu_wr_n,
   output logic             mcu_dc,
   output logic             pixel_clock_pin,
   output logic             vsync_n,
   output logic             hsync_n,
   output logic             data_enable,
   output logic      [17:0] video_data_lines
);
   logic [2:0] ph;

   // ====================
   // pins at rest
   initial begin
      ph = 3'h0;
      interface_select_pins = 3'h7;
      mcu_wr_n = 1'b1;
      mcu_dc = 1'b0;
      pixel_clock_pin = 1'b1;
      vsync_n = 1'b1;
      hsync_n = 1'b1;
      data_enable = 1'b0;
      video_data_lines = 18'h0;
   end

   // pixel clock never stops: 8 pclk a period, falls when ph was 0
   always @(posedge pclk) begin
      ph <= ph + 3'h1;
      pixel_clock_pin <= ph[2];
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // synchroniser needs a few cycles before the new code counts
   task automatic pins(input logic [2:0] p);
      @(posedge pclk);
      interface_select_pins <= p;
      cyc(5);
   endtask

   // ====================
   // one strobe, data held 4 cycles past the rising edge
   task automatic mcu_write(input logic dc, input logic [17:0] d);
      @(posedge pclk);
      video_data_lines <= d;
      mcu_dc <= dc;
      mcu_wr_n <= 1'b0;
      cyc(4);
      mcu_wr_n <= 1'b1;
      cyc(4);
      video_data_lines <= ~d;
   endtask

   // ====================
   // one pixel clock period of 8 pclk; released data lines flip, enable and syncs return to idle
   task automatic pixel(input logic de, vs_n, hs_n, input logic [17:0] d);
      do @(posedge pclk); while (ph != 3'h0);
      video_data_lines <= d;
      data_enable <= de;
      vsync_n <= vs_n;
      hsync_n <= hs_n;
      cyc(4); // rise of the pixel clock
      cyc(4);
      video_data_lines <= ~d;
      data_enable <= 1'b0;
      vsync_n <= 1'b1;
      hsync_n <= 1'b1;
   endtask
endmodule // hpu_host_model

`default_nettype wire

/* bench/host_pixel_data_unpacker_tb.sv */
/*
 * self-checking bench of the unpacker: apb tasks, host model, pixel queue.
 * assumes the host model and the constants header are compiled alongside.
 */
`timescale 1ns/1ps
`default_nettype none
`include "hpu_regs.svh"

module host_pixel_data_unpacker_tb
   import hpu_pkg::*;
;
   localparam logic [5:0]  CR = 6'h2D;
   localparam logic [5:0]  CG = 6'h1B;
   localparam logic [5:0]  CB = 6'h36;
   localparam logic [17:0] RGB = {CR, CG, CB};
   localparam logic [15:0] D565 = {CR[4:0], CG, CB[4:0]};
   localparam logic [17:0] E565 = {CR[4:0], CR[4], CG, CB[4:0], CB[4]};

   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        fm_we, fm_fs, even, zx, pol, pol0;
   logic        wr_n, dc, pixclk, vs_n, hs_n, de;
   logic [2:0]  ifsel;
   logic [17:0] fm_data, vdl;
   logic [17:0] pix_q[$];
   int          errors, comparisons, frames, cycles;

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   hpu_host_model hpu_host_model_i (.pclk(pclk), .interface_select_pins(ifsel),
      .mcu_wr_n(wr_n), .mcu_dc(dc), .pixel_clock_pin(pixclk), .vsync_n(vs_n),
      .hsync_n(hs_n), .data_enable(de), .video_data_lines(vdl));

   hpu_unpacker hpu_unpacker_i (.pclk(pclk), .presetn(presetn), .pclken(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .interface_select_pins(ifsel), .mcu_wr_n(wr_n), .mcu_dc(dc),
      .pixel_clock_pin(pixclk), .vsync_n(vs_n), .hsync_n(hs_n), .data_enable(de),
      .video_data_lines(vdl), .frame_memory_wr_en(fm_we),
      .frame_memory_wr_data(fm_data), .frame_memory_frame_start(fm_fs),
      .gate_line_even(even), .zinv_extra_line_en(zx), .source_polarity(pol));

   // ====================
   // monitor and hang limit
   always @(posedge pclk) begin
      cycles++;
      if (fm_we === 1'b1) begin
         pix_q.push_back(fm_data);
      end
      if (fm_fs === 1'b1) begin
         frames++;
      end
      if (cycles == 30000) begin
         errors++;
         $display("[FAIL] %0t run did not complete", $time);
         finish_test();
      end
   end

   // ====================
   // tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic ee);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
      chk(err, ee);
   endtask

   // pixel expected within a bounded wait
   task automatic expect_pix(input logic [17:0] e);
      int          n;
      logic [17:0] g;
      n = 0;
      g = 'x;
      while (pix_q.size() == 0 && n < 40) begin
         @(posedge pclk);
         n++;
      end
      if (pix_q.size() != 0) begin
         g = pix_q.pop_front();
      end
      chk({14'h0, g}, {14'h0, e});
   endtask

   task automatic tdone(input string s);
      $display("test %s done", s);
   endtask

   task automatic finish_test();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ====================
   // main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rchk(`HPU_OFS_CTRL, `HPU_CTRL_RESET, 1'b0);
      rchk(12'h008, 32'h0, 1'b1);
      apb(1'b1, `HPU_OFS_STATUS, 32'hFFFF_FFFF);
      apb(1'b0, `HPU_OFS_STATUS, 32'h0);
      chk(rd[5:0], 6'h0);
      tdone("registers");
      hpu_host_model_i.pins(`HPU_IM_BUS18);
      hpu_host_model_i.mcu_write(1'b0, 18'h3FFFF);
      hpu_host_model_i.cyc(8);
      chk(pix_q.size(), 0);
      hpu_host_model_i.mcu_write(1'b1, RGB);
      expect_pix(RGB);
      apb(1'b0, `HPU_OFS_STATUS, 32'h0);
      chk(rd[2:0], MODE_MCU18);
      tdone("bus18");
      hpu_host_model_i.pins(`HPU_IM_BUS9);
      hpu_host_model_i.mcu_write(1'b1, {9'h1FF, CR, CG[5:3]});
      hpu_host_model_i.mcu_write(1'b1, {9'h0AA, CG[2:0], CB});
      expect_pix(RGB);
      tdone("bus9");
      hpu_host_model_i.pins(`HPU_IM_BUS16);
      hpu_host_model_i.mcu_write(1'b1, {2'b11, D565});
      expect_pix(E565);
      apb(1'b1, `HPU_OFS_CTRL, 32'h100);
      hpu_host_model_i.mcu_write(1'b1, {2'b11, CR, 2'b01, CG, 2'b10});
      apb(1'b0, `HPU_OFS_STATUS, 32'h0);
      chk(rd[3:0], {1'b1, MODE_MCU16});
      chk(pix_q.size(), 0);
      hpu_host_model_i.mcu_write(1'b1, {2'b01, CB, 10'h155});
      expect_pix(RGB);
      tdone("bus16");
      apb(1'b1, `HPU_OFS_CTRL, 32'h6);
      pol0 = pol;
      hpu_host_model_i.pixel(1'b0, 1'b0, 1'b1, 18'h0);
      hpu_host_model_i.pixel(1'b0, 1'b1, 1'b0, 18'h0);
      chk(frames, 1);
      chk(pol, !pol0);
      chk(even, 1'b0);
      hpu_host_model_i.pixel(1'b1, 1'b1, 1'b1, RGB);
      expect_pix(RGB);
      hpu_host_model_i.pixel(1'b0, 1'b1, 1'b1, ~RGB);
      hpu_host_model_i.cyc(8);
      chk(pix_q.size(), 0);
      tdone("video18");
      apb(1'b1, `HPU_OFS_CTRL, 32'h16);
      hpu_host_model_i.pixel(1'b0, 1'b1, 1'b0, 18'h0);
      chk({zx, even}, 2'b11);
      hpu_host_model_i.pixel(1'b1, 1'b1, 1'b1, RGB);
      expect_pix({CG, CB, CR});
      hpu_host_model_i.pixel(1'b0, 1'b1, 1'b0, 18'h0);
      hpu_host_model_i.pixel(1'b1, 1'b1, 1'b1, RGB);
      expect_pix(RGB);
      tdone("zinv");
      apb(1'b1, `HPU_OFS_CTRL, 32'h5);
      hpu_host_model_i.pixel(1'b0, 1'b0, 1'b1, 18'h0);
      hpu_host_model_i.pixel(1'b0, 1'b1, 1'b0, 18'h0);
      hpu_host_model_i.pixel(1'b1, 1'b1, 1'b1, {2'b10, D565});
      expect_pix(E565);
      apb(1'b0, `HPU_OFS_STATUS, 32'h0);
      chk(rd[2:0], MODE_RGB16);
      chk(frames, 2);
      tdone("video16");
      finish_test();
   end
endmodule // host_pixel_data_unpacker_tb

`default_nettype wire
